// *** rtl/tsop_pkg.sv ***
// constants shared by the transport stream output port and its control slave
package tsop_pkg;
   // ==========================================================
   // control bus address and register indices
   localparam logic [4:0] DEV_ADDR_HIGH = 5'h02;
   localparam logic [7:0] IDX_POLARITY = 8'h12;
   localparam logic [7:0] IDX_UNCORR_COUNT = 8'h13;
   localparam logic [7:0] IDX_STREAM_MODE = 8'h20;
   // ==========================================================
   // output_polarity_ctrl fields
   localparam int POL_CLK_BIT = 0;
   localparam int POL_VALID_BIT = 1;
   localparam int POL_UNCORR_BIT = 2;
   localparam int POL_START_BIT = 3;
   localparam logic [7:0] POLARITY_RESET = 8'h80;
   localparam logic [7:0] POLARITY_FIXED_ONES = 8'h80;
   // ==========================================================
   // stream_mode_ctrl fields
   localparam int MODE_SERIAL_BIT = 0;
   localparam int MODE_MSB_FIRST_BIT = 1;
   localparam int MODE_PAR_B_BIT = 3;
   localparam int MODE_DIV_LSB = 4;
   localparam logic [7:0] STREAM_MODE_RESET = 8'h00;
   // ==========================================================
   // stream format
   localparam logic [7:0] PKT_BYTES = 8'hBC;
   localparam logic [7:0] SYNC_BYTE = 8'h47;
   localparam logic [6:0] UNCORR_COUNT_MAX = 7'h7F;
   // ==========================================================
   // output clock timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int PAR_HALF_NS = 56;
   localparam int SER_HALF_NS = 7;
   localparam int PAR_HALF_CYC = (PAR_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SER_HALF_CYC = (SER_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// *** rtl/tsop_reg_if.sv ***
// register access carrier between the control slave and the stream port
`timescale 1ns/1ps
`default_nettype none
interface tsop_reg_if;
   logic wr_stb;
   logic [7:0] idx;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport slave (output wr_stb, output idx, output wdata, input rdata);
   modport regs (input wr_stb, input idx, input wdata, output rdata);
endinterface
`default_nettype wire

// *** rtl/tsop_ctrl_slave.sv ***
// two-wire control slave: index write, data write and data read with auto increment
`timescale 1ns/1ps
`default_nettype none
module tsop_ctrl_slave
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic [1:0] i_addr_strap,
   output logic o_sda_oe,
   tsop_reg_if.slave bus
);
   typedef enum {ST_IDLE, ST_ADDR, ST_INDEX, ST_WDATA, ST_RDATA} tsop_cs_state_type;
   typedef struct packed {
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      logic scl_a;
      logic sda_a;
      logic [1:0] strap;
      tsop_cs_state_type st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic rw;
      logic nack;
      logic [7:0] idx;
      logic wr_stb;
      logic [7:0] wdata;
      logic oe;
   } tsop_cs_type;
   tsop_cs_type s_reg, s_next;
   logic scl_n, sda_n, rise, fall, start, stop;

   always_comb
   begin
      s_next = s_reg;
      s_next.wr_stb = 1'b0;
      // ==========================================================
      // three-stage synchronisers, level accepted once stages two and three agree
      s_next.scl_s = {s_reg.scl_s[1:0], i_scl};
      s_next.sda_s = {s_reg.sda_s[1:0], i_sda};
      scl_n = (s_reg.scl_s[1] == s_reg.scl_s[2]) ? s_reg.scl_s[2] : s_reg.scl_a;
      sda_n = (s_reg.sda_s[1] == s_reg.sda_s[2]) ? s_reg.sda_s[2] : s_reg.sda_a;
      s_next.scl_a = scl_n;
      s_next.sda_a = sda_n;
      rise = scl_n & ~s_reg.scl_a;
      fall = ~scl_n & s_reg.scl_a;
      start = scl_n & s_reg.scl_a & s_reg.sda_a & ~sda_n;
      stop = scl_n & s_reg.scl_a & ~s_reg.sda_a & sda_n;
      // ==========================================================
      // byte engine
      if (start)
      begin
         // a repeated start after the index write begins the read phase;
         // the scl fall that closes the start is no data bit, so it is marked to be skipped
         s_next.st = ST_ADDR;
         s_next.cnt = 4'hF;
         s_next.oe = 1'b0;
      end
      else if (stop)
      begin
         s_next.st = ST_IDLE;
         s_next.oe = 1'b0;
      end
      else if (s_reg.st != ST_IDLE)
      begin
         if (rise)
         begin
            if (s_reg.cnt < 4'h8)
               s_next.sh = {s_reg.sh[6:0], sda_n};
            else
               s_next.nack = sda_n;
         end
         else if (fall)
         begin
            if (s_reg.cnt == 4'hF)
               s_next.cnt = 4'h0;
            else if (s_reg.st == ST_RDATA && s_reg.cnt < 4'h7)
            begin
               // the rising edge has already shifted, so the next bit sits at the top
               s_next.cnt = s_reg.cnt + 4'h1;
               s_next.oe = ~s_reg.sh[7];
            end
            else if (s_reg.cnt < 4'h7)
               s_next.cnt = s_reg.cnt + 4'h1;
            else if (s_reg.cnt == 4'h7)
            begin
               s_next.cnt = 4'h8;
               s_next.oe = (s_reg.st != ST_RDATA);
               case (s_reg.st)
                  ST_ADDR:
                  begin
                     s_next.rw = s_reg.sh[0];
                     if (s_reg.sh[7:1] != {tsop_pkg::DEV_ADDR_HIGH, s_reg.strap})
                     begin
                        s_next.st = ST_IDLE;
                        s_next.oe = 1'b0;
                     end
                  end
                  ST_INDEX: s_next.idx = s_reg.sh;
                  ST_WDATA:
                  begin
                     s_next.wr_stb = 1'b1;
                     s_next.wdata = s_reg.sh;
                  end
                  default: s_next.oe = 1'b0;
               endcase
            end
            else
            begin
               s_next.cnt = 4'h0;
               s_next.oe = 1'b0;
               case (s_reg.st)
                  ST_ADDR:
                  begin
                     if (s_reg.rw)
                     begin
                        s_next.st = ST_RDATA;
                        s_next.sh = bus.rdata;
                        s_next.oe = ~bus.rdata[7];
                        s_next.idx = s_reg.idx + 8'h01;
                     end
                     else
                        s_next.st = ST_INDEX;
                  end
                  ST_INDEX: s_next.st = ST_WDATA;
                  ST_WDATA: s_next.idx = s_reg.idx + 8'h01;
                  ST_RDATA:
                  begin
                     if (s_reg.nack)
                        s_next.st = ST_IDLE;
                     else
                     begin
                        s_next.sh = bus.rdata;
                        s_next.oe = ~bus.rdata[7];
                        s_next.idx = s_reg.idx + 8'h01;
                     end
                  end
                  default: s_next.st = ST_IDLE;
               endcase
            end
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         s_reg <= '0;
         s_reg.scl_s <= 3'h7;
         s_reg.sda_s <= 3'h7;
         s_reg.scl_a <= 1'b1;
         s_reg.sda_a <= 1'b1;
         s_reg.st <= ST_IDLE;
         s_reg.strap <= i_addr_strap; // straps caught while reset is held
      end
      else
         s_reg <= s_next;
   end

   assign o_sda_oe = s_reg.oe;
   assign bus.wr_stb = s_reg.wr_stb;
   assign bus.idx = s_reg.idx;
   assign bus.wdata = s_reg.wdata;
endmodule // tsop_ctrl_slave
`default_nettype wire

// *** rtl/tsop_stream_port.sv ***
// transport stream output port: parallel modes A and B, serial mode, control registers
`timescale 1ns/1ps
`default_nettype none
module tsop_stream_port
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic [1:0] i_addr_strap,
   output logic o_sda_out,
   output logic o_sda_oe,
   input wire logic i_byte_valid,
   input wire logic [7:0] i_byte_data,
   input wire logic i_byte_first,
   input wire logic i_byte_uncorr,
   output logic o_byte_taken,
   output logic [7:0] o_data,
   output logic o_stream_clk,
   output logic o_data_valid,
   output logic o_packet_start,
   output logic o_uncorr_flag
);
   typedef struct packed {
      logic [7:0] pol;
      logic [7:0] mode;
      logic [6:0] uncnt;
      logic [4:0] half;
      logic clk_lvl;
      logic [7:0] sh;
      logic [2:0] bits_left;
      logic [7:0] pkt_cnt;
      logic pkt_bad;
      logic output_data_valid;
      logic start;
      logic uncorrectable_packet_flag;
      logic [7:0] dout;
      logic taken;
   } tsop_sp_type;
   tsop_sp_type s_reg, s_next;
   tsop_reg_if rif ();

   // ==========================================================
   // control slave
   tsop_ctrl_slave u_ctrl
   (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_scl(i_scl),
      .i_sda(i_sda),
      .i_addr_strap(i_addr_strap),
      .o_sda_oe(o_sda_oe),
      .bus(rif.slave)
   );

   // half period of the output clock in cycles, by mode
   function automatic logic [4:0] half_cycles(input logic [7:0] mode);
      if (mode[tsop_pkg::MODE_SERIAL_BIT])
         half_cycles = 5'(tsop_pkg::SER_HALF_CYC);
      else if (mode[tsop_pkg::MODE_PAR_B_BIT])
         half_cycles = {1'b0, mode[tsop_pkg::MODE_DIV_LSB +: 4]} + 5'h01;
      else
         half_cycles = 5'(tsop_pkg::PAR_HALF_CYC);
   endfunction

   // ==========================================================
   // register read mux
   always_comb
   begin
      case (rif.idx)
         tsop_pkg::IDX_POLARITY: rif.rdata = s_reg.pol | tsop_pkg::POLARITY_FIXED_ONES;
         tsop_pkg::IDX_UNCORR_COUNT: rif.rdata = {1'b0, s_reg.uncnt};
         tsop_pkg::IDX_STREAM_MODE: rif.rdata = s_reg.mode;
         default: rif.rdata = 8'h00;
      endcase
   end

   logic serial, msb_first, par_b, period_start, clk_n;
   logic [7:0] cnt_n, byte_n;
   logic [7:0] raw_data;
   logic raw_den, raw_start, raw_uncorrectable_packet_flag;

   always_comb
   begin
      s_next = s_reg;
      s_next.taken = 1'b0;
      serial = s_reg.mode[tsop_pkg::MODE_SERIAL_BIT];
      msb_first = s_reg.mode[tsop_pkg::MODE_MSB_FIRST_BIT];
      par_b = s_reg.mode[tsop_pkg::MODE_PAR_B_BIT];
      cnt_n = 8'h00;
      byte_n = i_byte_data;
      // outputs hold their raw (uninverted) values in the state copy
      raw_data = s_reg.dout;
      raw_den = s_reg.output_data_valid;
      raw_start = s_reg.start;
      raw_uncorrectable_packet_flag = s_reg.uncorrectable_packet_flag;
      clk_n = s_reg.clk_lvl;
      // ==========================================================
      // register writes
      if (rif.wr_stb)
      begin
         if (rif.idx == tsop_pkg::IDX_POLARITY)
            s_next.pol = rif.wdata | tsop_pkg::POLARITY_FIXED_ONES;
         if (rif.idx == tsop_pkg::IDX_STREAM_MODE)
            s_next.mode = rif.wdata;
      end
      // ==========================================================
      // output clock and data sequencing; data changes with the rising edge
      period_start = ~s_reg.clk_lvl && (s_reg.half == 5'h00);
      if (period_start)
      begin
         if (serial && s_reg.bits_left != 3'h0)
         begin
            // next bit of the byte in flight; sync flag only on the first bit
            clk_n = 1'b1;
            raw_data = {7'h00, msb_first ? s_reg.sh[7] : s_reg.sh[0]};
            s_next.sh = msb_first ? {s_reg.sh[6:0], 1'b0} : {1'b0, s_reg.sh[7:1]};
            s_next.bits_left = s_reg.bits_left - 3'h1;
            raw_start = 1'b0;
            s_next.half = half_cycles(s_reg.mode) - 5'h01;
         end
         else if (i_byte_valid)
         begin
            // a jittered clock results in mode A and serial, since periods run only with data
            clk_n = 1'b1;
            s_next.taken = 1'b1;
            s_next.half = half_cycles(s_reg.mode) - 5'h01;
            if (i_byte_first)
               cnt_n = 8'h01;
            else if (s_reg.pkt_cnt != 8'h00 && s_reg.pkt_cnt < tsop_pkg::PKT_BYTES)
               cnt_n = s_reg.pkt_cnt + 8'h01;
            s_next.pkt_cnt = cnt_n;
            if (i_byte_first)
            begin
               s_next.pkt_bad = i_byte_uncorr;
               if (i_byte_uncorr && s_reg.uncnt != tsop_pkg::UNCORR_COUNT_MAX)
                  s_next.uncnt = s_reg.uncnt + 7'h01;
            end
            // the strobe covers 188 bytes, in serial that is 188 x 8 = 1504 bit periods
            raw_den = (cnt_n != 8'h00);
            raw_uncorrectable_packet_flag = (cnt_n != 8'h00) && (i_byte_first ? i_byte_uncorr : s_reg.pkt_bad);
            raw_start = (cnt_n == 8'h01) && (byte_n == tsop_pkg::SYNC_BYTE);
            if (serial)
            begin
               raw_data = {7'h00, msb_first ? byte_n[7] : byte_n[0]};
               s_next.sh = msb_first ? {byte_n[6:0], 1'b0} : {1'b0, byte_n[7:1]};
               s_next.bits_left = 3'h7;
            end
            else
               raw_data = byte_n;
         end
         else if (par_b && !serial)
         begin
            // mode B keeps clocking; an empty period shows no valid data
            clk_n = 1'b1;
            raw_den = 1'b0;
            raw_start = 1'b0;
            raw_uncorrectable_packet_flag = 1'b0;
            s_next.half = half_cycles(s_reg.mode) - 5'h01;
         end
      end
      else if (s_reg.half == 5'h00)
      begin
         clk_n = 1'b0;
         s_next.half = half_cycles(s_reg.mode) - 5'h01;
      end
      else
         s_next.half = s_reg.half - 5'h01;
      s_next.clk_lvl = clk_n;
      s_next.dout = raw_data;
      s_next.output_data_valid = raw_den;
      s_next.start = raw_start;
      s_next.uncorrectable_packet_flag = raw_uncorrectable_packet_flag;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         s_reg <= '0;
         s_reg.pol <= tsop_pkg::POLARITY_RESET;
         s_reg.mode <= tsop_pkg::STREAM_MODE_RESET;
         o_stream_clk <= 1'b0;
         o_data_valid <= 1'b0;
         o_packet_start <= 1'b0;
         o_uncorr_flag <= 1'b0;
         o_data <= 8'h00;
         o_byte_taken <= 1'b0;
      end
      else
      begin
         s_reg <= s_next;
         // ==========================================================
         // output pins; clock, valid, start and uncorrectable flags have programmable polarity, data and taken do not
         o_stream_clk <= s_next.clk_lvl ^ s_next.pol[tsop_pkg::POL_CLK_BIT];
         o_data_valid <= s_next.output_data_valid ^ s_next.pol[tsop_pkg::POL_VALID_BIT];
         o_packet_start <= s_next.start ^ s_next.pol[tsop_pkg::POL_START_BIT];
         o_uncorr_flag <= s_next.uncorrectable_packet_flag ^ s_next.pol[tsop_pkg::POL_UNCORR_BIT];
         o_data <= s_next.dout;
         o_byte_taken <= s_next.taken;
      end
   end

   // open-drain line: only ever pulled low
   assign o_sda_out = 1'b0;
endmodule // tsop_stream_port
`default_nettype wire

// *** dv/tsop_port_chk.sv ***
// pin-level checker for the transport stream output port
`timescale 1ns/1ps
`default_nettype none
module tsop_port_chk
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_scl,
   input wire logic i_byte_valid,
   input wire logic [7:0] i_byte_data,
   input wire logic i_byte_first,
   input wire logic o_sda_out,
   input wire logic o_sda_oe,
   input wire logic o_byte_taken,
   input wire logic [7:0] o_data,
   input wire logic o_stream_clk,
   input wire logic o_data_valid,
   input wire logic o_packet_start,
   input wire logic o_uncorr_flag
);
   logic first_reg;
   logic sync_reg;
   logic syn_reg;
   logic vld_reg;
   logic unc_reg;
   logic st_reg;
   logic [7:0] cnt_reg;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   // ==========================================================
   // packet tracking: levels seen at the first byte are the active ones
   always_ff @(posedge i_clk)
   begin
      first_reg <= i_byte_first;
      sync_reg <= (i_byte_data == tsop_pkg::SYNC_BYTE);
      if (i_sys_rst)
         cnt_reg <= 8'h00;
      else if (o_byte_taken && first_reg)
      begin
         cnt_reg <= 8'h01;
         vld_reg <= o_data_valid;
         unc_reg <= o_uncorr_flag;
         st_reg <= o_packet_start;
         syn_reg <= sync_reg;
      end
      else if (o_byte_taken && cnt_reg != 8'h00 && cnt_reg < tsop_pkg::PKT_BYTES)
         cnt_reg <= cnt_reg + 8'h01;
   end
   sequence s_take;
      o_byte_taken ##1 !o_byte_taken;
   endsequence
   // ==========================================================
   // assertions
   reset_quiet_a: assert property (disable iff (1'b0) i_sys_rst |=>
      !o_sda_oe && !o_byte_taken && o_data == 8'h00 && !o_stream_clk) else $error("outputs not quiet after reset");
   sda_drive_a: assert property (o_sda_out == 1'b0) else $error("sda value not low");
   ack_scl_low_a: assert property ($changed(o_sda_oe) |-> !i_scl) else $error("sda moved while scl high");
   take_pulse_a: assert property (o_byte_taken |-> s_take) else $error("taken longer than one cycle");
   take_cause_a: assert property (o_byte_taken |-> $past(i_byte_valid)) else $error("byte taken without offer");
   clk_turn_a: assert property (o_byte_taken |-> o_stream_clk != $past(o_stream_clk))
      else $error("no clock edge with byte");
   data_source_a: assert property (o_byte_taken |-> o_data == $past(i_byte_data) ||
      o_data == {7'h00, $past(i_byte_data[7])} || o_data == {7'h00, $past(i_byte_data[0])}) else $error("bad data");
   data_hold_a: assert property (o_byte_taken |=> $stable(o_data) && $stable(o_data_valid))
      else $error("data not held");
   pkt_valid_a: assert property (o_byte_taken && !first_reg && cnt_reg != 8'h00 |->
      (o_data_valid == vld_reg) == (cnt_reg < tsop_pkg::PKT_BYTES)) else $error("valid span wrong");
   pkt_uncorr_a: assert property (o_byte_taken && !first_reg && cnt_reg != 8'h00 &&
      cnt_reg < tsop_pkg::PKT_BYTES |-> o_uncorr_flag == unc_reg) else $error("uncorrectable flag moved");
   pkt_start_a: assert property (o_byte_taken && !first_reg && cnt_reg != 8'h00 && syn_reg |->
      o_packet_start != st_reg) else $error("start flag outside sync");
endmodule // tsop_port_chk
bind tsop_stream_port tsop_port_chk u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_scl(i_scl),
   .i_byte_valid(i_byte_valid), .i_byte_data(i_byte_data), .i_byte_first(i_byte_first), .o_sda_out(o_sda_out),
   .o_sda_oe(o_sda_oe), .o_byte_taken(o_byte_taken), .o_data(o_data), .o_stream_clk(o_stream_clk),
   .o_data_valid(o_data_valid), .o_packet_start(o_packet_start), .o_uncorr_flag(o_uncorr_flag));
`default_nettype wire

// *** dv/tsop_ts_sink.sv ***
// demultiplexer-side model: samples the stream on the falling active clock edge
`timescale 1ns/1ps
`default_nettype none
module tsop_ts_sink
(
   input wire logic i_clk,
   input wire logic i_clear,
   input wire logic [3:0] i_pol,
   input wire logic i_serial,
   input wire logic i_msb_first,
   input wire logic [7:0] i_data,
   input wire logic i_stream_clk,
   input wire logic i_data_valid,
   input wire logic i_packet_start,
   input wire logic i_uncorr_flag,
   output logic [15:0] o_valid_cnt,
   output logic [15:0] o_start_cnt,
   output logic [15:0] o_uncorr_cnt,
   output logic [7:0] o_start_byte,
   output logic [7:0] o_last_byte
);
   logic clk_q;
   logic mark;
   logic [2:0] nbit;
   logic [7:0] sh;
   always @(posedge i_clk)
   begin : sample
      logic [7:0] b;
      logic st;
      b = i_serial ? (i_msb_first ? {sh[6:0], i_data[0]} : {i_data[0], sh[7:1]}) : i_data;
      st = i_packet_start != i_pol[3];
      clk_q <= i_stream_clk ^ i_pol[0];
      if (i_clear)
      begin
         o_valid_cnt <= 16'h0000;
         o_start_cnt <= 16'h0000;
         o_uncorr_cnt <= 16'h0000;
         nbit <= 3'h0;
         mark <= 1'b0;
      end
      else if (clk_q && !(i_stream_clk ^ i_pol[0]))
      begin
         if (st)
            o_start_cnt <= o_start_cnt + 16'h0001;
         if (i_uncorr_flag != i_pol[2])
            o_uncorr_cnt <= o_uncorr_cnt + 16'h0001;
         if (i_data_valid != i_pol[1])
         begin
            o_valid_cnt <= o_valid_cnt + 16'h0001;
            sh <= b;
            nbit <= nbit + 3'h1;
            if (nbit == 3'h0)
               mark <= st;
            if (!i_serial || nbit == 3'h7)
               o_last_byte <= b;
            if ((!i_serial && st) || (i_serial && nbit == 3'h7 && mark))
               o_start_byte <= b;
         end
      end
   end
endmodule // tsop_ts_sink
`default_nettype wire

// *** dv/tsop_stream_port_tb.sv ***
// self-checking bench for the transport stream output port
`timescale 1ns/1ps
`default_nettype none
module tsop_stream_port_tb;
   // stream modes: A, B with divisor field 2, serial msb first, serial lsb first
   localparam logic [31:0] MODES = 32'h01032800;
   localparam logic [15:0] POLS = 16'hA5F0;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic scl = 1'b1;
   logic sda_m = 1'b1;
   logic [1:0] strap = 2'h2;
   logic bv = 1'b0;
   logic [7:0] bd = 8'h00;
   logic bf = 1'b0;
   logic bu = 1'b0;
   logic clr = 1'b1;
   logic [3:0] pol = 4'h0;
   logic ser = 1'b0;
   logic msbf = 1'b0;
   logic sda_out, sda_oe, taken, sclk, dv, ps, uf;
   logic [7:0] dq, sb, lb;
   logic [15:0] vc, sc, uc;
   int miscompares = 0;
   int checked = 0;
   int cyc = 0;
   // open drain line with pull-up
   wire logic sda = sda_m & ~sda_oe;
   always #4 i_clk = ~i_clk;
   tsop_stream_port uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_scl(scl), .i_sda(sda), .i_addr_strap(strap),
      .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_byte_valid(bv), .i_byte_data(bd), .i_byte_first(bf),
      .i_byte_uncorr(bu), .o_byte_taken(taken), .o_data(dq), .o_stream_clk(sclk), .o_data_valid(dv),
      .o_packet_start(ps), .o_uncorr_flag(uf));
   tsop_ts_sink u_sink (.i_clk(i_clk), .i_clear(clr), .i_pol(pol), .i_serial(ser), .i_msb_first(msbf),
      .i_data(dq), .i_stream_clk(sclk), .i_data_valid(dv), .i_packet_start(ps), .i_uncorr_flag(uf),
      .o_valid_cnt(vc), .o_start_cnt(sc), .o_uncorr_cnt(uc), .o_start_byte(sb), .o_last_byte(lb));
   // ==========================================================
   // helpers
   task automatic wt(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e)
      begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cmp_cnt(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e)
      begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task give_verdict;
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ==========================================================
   // two-wire master, steps of 10 cycles: scl high for 10 and low for 20 per bit
   task automatic bit_io(input logic b, output logic r);
      sda_m <= b;
      wt(10);
      scl <= 1'b1;
      wt(10);
      r = sda;
      scl <= 1'b0;
      wt(10);
   endtask
   task automatic start_c;
      sda_m <= 1'b1;
      wt(10);
      scl <= 1'b1;
      wt(10);
      sda_m <= 1'b0;
      wt(10);
      scl <= 1'b0;
      wt(10);
   endtask
   task automatic stop_c;
      sda_m <= 1'b0;
      wt(10);
      scl <= 1'b1;
      wt(10);
      sda_m <= 1'b1;
      wt(10);
   endtask
   task automatic send(input logic [7:0] d, input logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r);
      bit_io(1'b1, r);
      cmp_byte({7'h00, ~r}, {7'h00, ack});
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      start_c;
      send({tsop_pkg::DEV_ADDR_HIGH, strap, 1'b0}, 1'b1);
      send(idx, 1'b1);
      send(v, 1'b1);
      stop_c;
      wt(10);
   endtask
   task automatic rd(input logic [7:0] idx, output logic [7:0] v);
      logic r;
      start_c;
      send({tsop_pkg::DEV_ADDR_HIGH, strap, 1'b0}, 1'b1);
      send(idx, 1'b1);
      start_c;
      send({tsop_pkg::DEV_ADDR_HIGH, strap, 1'b1}, 1'b1);
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(1'b1, r);
         v[i] = r;
      end
      bit_io(1'b1, r);
      stop_c;
   endtask
   // ==========================================================
   // scenarios
   task automatic t_regs;
      logic [7:0] v;
      rd(tsop_pkg::IDX_POLARITY, v);
      cmp_byte(v, tsop_pkg::POLARITY_RESET);
      wr(tsop_pkg::IDX_POLARITY, 8'h0F);
      rd(tsop_pkg::IDX_POLARITY, v);
      cmp_byte(v, 8'h8F);
      rd(8'h55, v);
      cmp_byte(v, 8'h00);
      start_c;
      send({tsop_pkg::DEV_ADDR_HIGH, ~strap, 1'b0}, 1'b0);
      stop_c;
      $display("test regs done");
   endtask
   // stalls every 32 bytes so mode B shows idle periods and mode A its stopped clock
   task automatic send_pkt(input logic unc);
      int n;
      for (int k = 0; k < 189; k++)
      begin
         bv <= 1'b1;
         bd <= (k == 0) ? tsop_pkg::SYNC_BYTE : k[7:0];
         bf <= (k == 0);
         bu <= unc;
         @(posedge i_clk);
         for (n = 0; taken !== 1'b1 && n < 300; n++)
            @(posedge i_clk);
         cmp_byte({7'h00, taken}, 8'h01);
         if (k % 32 == 31)
         begin
            bv <= 1'b0;
            wt(40);
         end
      end
      bv <= 1'b0;
   endtask
   task automatic t_stream;
      logic [15:0] nb;
      for (int c = 0; c < 4; c++)
      begin
         wr(tsop_pkg::IDX_STREAM_MODE, MODES[8*c +: 8]);
         wr(tsop_pkg::IDX_POLARITY, {4'h0, POLS[4*c +: 4]});
         pol <= POLS[4*c +: 4];
         ser <= MODES[8*c];
         msbf <= MODES[8*c+1];
         clr <= 1'b1;
         wt(2);
         clr <= 1'b0;
         send_pkt(c[0]);
         wt(100);
         nb = MODES[8*c] ? 16'h05E0 : 16'h00BC;
         cmp_cnt(vc, nb);
         cmp_cnt(sc, 16'h0001);
         cmp_cnt(uc, c[0] ? nb : 16'h0000);
         cmp_byte(sb, tsop_pkg::SYNC_BYTE);
         cmp_byte(lb, 8'hBB);
         $display("test stream config %0d done", c);
      end
   endtask
   task automatic t_reset;
      logic [7:0] v;
      i_sys_rst <= 1'b1;
      wt(2);
      i_sys_rst <= 1'b0;
      wt(6);
      rd(tsop_pkg::IDX_POLARITY, v);
      cmp_byte(v, tsop_pkg::POLARITY_RESET);
      rd(tsop_pkg::IDX_STREAM_MODE, v);
      cmp_byte(v, tsop_pkg::STREAM_MODE_RESET);
      $display("test reset done");
   endtask
   // ==========================================================
   // run control
   always @(posedge i_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         miscompares++;
         give_verdict;
      end
   end
   initial
   begin
      wt(10);
      i_sys_rst <= 1'b0;
      wt(6);
      t_regs;
      t_stream;
      t_reset;
      give_verdict;
   end
endmodule // tsop_stream_port_tb
`default_nettype wire
